// file: pkg/icsr_pkg.sv
package icsr_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0]  OFS_PRIO_EXT   = 8'h00;
    localparam logic [7:0]  OFS_NEST_TRAP  = 8'h04;
    localparam logic [7:0]  OFS_VEC_EDGE   = 8'h08;
    localparam logic [7:0]  OFS_FLAGS0     = 8'h0C;
    localparam logic [7:0]  OFS_FLAGS1     = 8'h10;
    localparam logic [7:0]  OFS_CPU_FIELD  = 8'h14;

    // Register select indices
    localparam int unsigned NUM_REGS       = 6;
    localparam int unsigned REG_PRIO_EXT   = 0;
    localparam int unsigned REG_NEST_TRAP  = 1;
    localparam int unsigned REG_VEC_EDGE   = 2;
    localparam int unsigned REG_FLAGS0     = 3;
    localparam int unsigned REG_FLAGS1     = 4;
    localparam int unsigned REG_CPU_FIELD  = 5;

    // Field positions
    localparam int unsigned PRIO_EXT_BIT   = 3;
    localparam int unsigned PRIO_RSVD_BIT  = 2;
    localparam int unsigned NEST_DIS_BIT   = 15;
    localparam int unsigned ARITH_BIT      = 4;
    localparam int unsigned ADDRESS_BIT    = 3;
    localparam int unsigned STACK_BIT      = 2;
    localparam int unsigned OSC_BIT        = 1;
    localparam int unsigned ALT_TABLE_BIT  = 15;
    localparam int unsigned TEMP_DIS_BIT   = 14;
    localparam int unsigned FIELD_LSB      = 5;
    localparam int unsigned FIELD_MSB      = 7;
    localparam int unsigned EXT0_FLAG_BIT  = 0;
    localparam int unsigned EXT1_FLAG_BIT  = 4;
    localparam int unsigned EXT2_FLAG_BIT  = 13;
    localparam int unsigned FLAGS0_GAP_BIT = 15;
    localparam int unsigned FLAGS1_GAP_BIT = 5;

    // Implemented-bit masks
    localparam logic [15:0] TRAP_MASK      = 16'h001E;
    localparam logic [15:0] POL_MASK       = 16'h001F;
    localparam logic [15:0] FLAGS0_MASK    = 16'h7FFF;
    localparam logic [15:0] FLAGS1_MASK    = 16'hFFDF;

    // Reset values
    localparam logic        RST_BIT        = 1'b0;
    localparam logic [15:0] RST_WORD       = 16'h0000;
    localparam logic [2:0]  RST_FIELD      = 3'h0;
    localparam logic [2:0]  FIELD_ALL_OFF  = 3'h7;

    // Bus encodings
    localparam logic [2:0]  HSIZE_WORD     = 3'h2;
    localparam logic        HRESP_OKAY     = 1'b0;

endpackage

// file: logic/icsr_edge_sync.sv
`timescale 1ns/1ps
module icsr_edge_sync (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Pin and polarity
    input  wire logic pin_in,
    input  wire logic falling_sel,
    // Detected edge
    output logic      edge_pulse
);

    logic s1_q, s2_q, s3_q, stable_q, edge_q;
    logic stable_d, edge_d;

    // Only s2 and s3 are looked at; s1 feeds s2 alone
    always_comb begin
        stable_d = stable_q;
        edge_d   = 1'b0;
        if (s2_q == s3_q) begin
            stable_d = s3_q;
            if (s3_q != stable_q) begin
                edge_d = falling_sel ? stable_q : s3_q;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q     <= 1'b0;
            s2_q     <= 1'b0;
            s3_q     <= 1'b0;
            stable_q <= 1'b0;
            edge_q   <= 1'b0;
        end else begin
            s1_q     <= pin_in;
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            stable_q <= stable_d;
            edge_q   <= edge_d;
        end
    end

    assign edge_pulse = edge_q;

endmodule

// file: logic/icsr_regs.sv
`timescale 1ns/1ps
// How it works
// RL1 - Extension bit: hardware sets, software clears
// RL2 - Level is extension bit above field
// RL3 - Reserved bit two reads one, rest zero
// RL4 - Nesting disable bit, read/write, reset zero
// RL5 - Arithmetic and address trap flags
// RL6 - Stack and oscillator trap flags
// RL7 - Bit fifteen selects alternate vector table
// RL8 - Temporary disable status is hardware driven
// RL9 - Polarity bits: one falling, zero rising
// RL10 - Flags read/write, reset zero, show requests
// RL11 - Bank zero low byte source order
// RL12 - Bank zero high byte, bit fifteen zero
// RL13 - Bank one high byte source order
// RL14 - Bank one low byte, bit five zero
// RL15 - Unimplemented control bits ignore writes, read zero
// RL16 - Hardware sets flags, software clears them
// RL17 - Field read-only while nesting disabled
// RL18 - Field all ones masks user interrupts
// RL19 - Synchronised pins, one flag per edge on lines zero to two; lines three and four set no flag
// RL20 - Hardware set beats same-cycle software write
module icsr_regs #(
    parameter int unsigned NUM_EXT = 5
) (
    // Clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // AHB-Lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    // Request sources
    input  wire logic [NUM_EXT-1:0] ext_irq_pin,
    input  wire logic [15:0]  periph_set_bank0,
    input  wire logic [15:0]  periph_set_bank1,
    // Trap and CPU events
    input  wire logic         trap_arith_set,
    input  wire logic         trap_address_set,
    input  wire logic         trap_stack_set,
    input  wire logic         trap_osc_set,
    input  wire logic         prio_ext_set,
    input  wire logic         cpu_field_load,
    input  wire logic [2:0]   cpu_field_value,
    input  wire logic         temp_disable_active,
    // State toward CPU and arbiter
    output logic [3:0]        cpu_priority_level,
    output logic              user_irq_disabled,
    output logic              nesting_disable,
    output logic              alternate_table_select,
    output logic [NUM_EXT-1:0] ext_irq_polarity,
    output logic [NUM_EXT-1:0] ext_irq_edge,
    output logic [15:0]       request_flags_bank0,
    output logic [15:0]       request_flags_bank1
);

    // Flag layout needs exactly five external lines
    if (NUM_EXT != 5) begin : g_bad_ext
        $error("icsr_regs supports NUM_EXT of 5 only");
    end

    function automatic logic [icsr_pkg::NUM_REGS-1:0] reg_sel(input logic [7:0] a);
        logic [icsr_pkg::NUM_REGS-1:0] s;
        s = '0;
        case (a)
            icsr_pkg::OFS_PRIO_EXT:  s[icsr_pkg::REG_PRIO_EXT]  = 1'b1;
            icsr_pkg::OFS_NEST_TRAP: s[icsr_pkg::REG_NEST_TRAP] = 1'b1;
            icsr_pkg::OFS_VEC_EDGE:  s[icsr_pkg::REG_VEC_EDGE]  = 1'b1;
            icsr_pkg::OFS_FLAGS0:    s[icsr_pkg::REG_FLAGS0]    = 1'b1;
            icsr_pkg::OFS_FLAGS1:    s[icsr_pkg::REG_FLAGS1]    = 1'b1;
            icsr_pkg::OFS_CPU_FIELD: s[icsr_pkg::REG_CPU_FIELD] = 1'b1;
            default:                 s = '0;
        endcase
        return s;
    endfunction

    // Register state
    logic                          prio_ext_q, prio_ext_d;
    logic                          nest_dis_q, nest_dis_d;
    logic [15:0]                   trap_q, trap_d;
    logic                          alt_q, alt_d;
    logic                          temp_dis_d;
    logic [NUM_EXT-1:0]            pol_q, pol_d;
    logic [15:0]                   flags0_q, flags0_d;
    logic [15:0]                   flags1_q, flags1_d;
    logic [2:0]                    field_q, field_d;
    logic [icsr_pkg::NUM_REGS-1:0] wsel_q, wsel_d;
    logic [31:0]                   hrdata_q, hrdata_d;

    logic                          addr_phase;
    logic [icsr_pkg::NUM_REGS-1:0] asel;
    logic [15:0]                   wdata;
    logic [15:0]                   trap_set;
    logic [15:0]                   set0;
    logic [15:0]                   set1;
    logic [15:0]                   rd_word;

    // Edge detectors on the external lines
    for (genvar i = 0; i < NUM_EXT; i++) begin : g_ext
        icsr_edge_sync u_edge (
            .hclk        (hclk),
            .hresetn     (hresetn),
            .pin_in      (ext_irq_pin[i]),
            .falling_sel (pol_q[i]),
            .edge_pulse  (ext_irq_edge[i])
        ); // RL19 RL9
    end

    assign addr_phase = hsel && hready && htrans[1];
    assign asel       = reg_sel(haddr[7:0]);
    assign wdata      = hwdata[15:0];

    always_comb begin
        trap_set = '0;
        trap_set[icsr_pkg::ARITH_BIT]   = trap_arith_set;   // RL5
        trap_set[icsr_pkg::ADDRESS_BIT] = trap_address_set; // RL5
        trap_set[icsr_pkg::STACK_BIT]   = trap_stack_set;   // RL6
        trap_set[icsr_pkg::OSC_BIT]     = trap_osc_set;     // RL6
        // Dedicated lines land in their vector-ordered slots
        set0 = periph_set_bank0 & icsr_pkg::FLAGS0_MASK; // RL11 RL12
        set1 = periph_set_bank1 & icsr_pkg::FLAGS1_MASK; // RL13 RL14
        set0[icsr_pkg::EXT0_FLAG_BIT] = set0[icsr_pkg::EXT0_FLAG_BIT] | ext_irq_edge[0];
        set1[icsr_pkg::EXT1_FLAG_BIT] = set1[icsr_pkg::EXT1_FLAG_BIT] | ext_irq_edge[1];
        set1[icsr_pkg::EXT2_FLAG_BIT] = set1[icsr_pkg::EXT2_FLAG_BIT] | ext_irq_edge[2];
    end

    // Next register values; writes land in the data phase
    always_comb begin
        prio_ext_d = prio_ext_q;
        if (wsel_q[icsr_pkg::REG_PRIO_EXT] && !wdata[icsr_pkg::PRIO_EXT_BIT]) begin
            prio_ext_d = 1'b0; // RL1
        end
        if (prio_ext_set) begin
            prio_ext_d = 1'b1; // RL1 RL20
        end

        nest_dis_d = nest_dis_q;
        trap_d     = trap_q;
        if (wsel_q[icsr_pkg::REG_NEST_TRAP]) begin
            nest_dis_d = wdata[icsr_pkg::NEST_DIS_BIT];    // RL4
            trap_d     = wdata & icsr_pkg::TRAP_MASK;      // RL15
        end
        trap_d = trap_d | trap_set;                        // RL20

        alt_d = alt_q;
        pol_d = pol_q;
        if (wsel_q[icsr_pkg::REG_VEC_EDGE]) begin
            alt_d = wdata[icsr_pkg::ALT_TABLE_BIT];        // RL7
            pol_d = wdata[NUM_EXT-1:0];                    // RL9
        end
        temp_dis_d = temp_disable_active;                  // RL8

        flags0_d = flags0_q;
        if (wsel_q[icsr_pkg::REG_FLAGS0]) begin
            flags0_d = wdata & icsr_pkg::FLAGS0_MASK;      // RL10 RL16
        end
        flags0_d = flags0_d | set0;                        // RL16 RL20

        flags1_d = flags1_q;
        if (wsel_q[icsr_pkg::REG_FLAGS1]) begin
            flags1_d = wdata & icsr_pkg::FLAGS1_MASK;      // RL10 RL16
        end
        flags1_d = flags1_d | set1;                        // RL16 RL20

        field_d = field_q;
        if (wsel_q[icsr_pkg::REG_CPU_FIELD] && !nest_dis_q) begin
            field_d = wdata[icsr_pkg::FIELD_MSB:icsr_pkg::FIELD_LSB]; // RL17
        end
        // CPU entry/return loads must pass even with nesting off
        if (cpu_field_load) begin
            field_d = cpu_field_value;
        end
    end

    // Read data taken from next values so a write just before is visible
    always_comb begin
        rd_word = '0;
        if (asel[icsr_pkg::REG_PRIO_EXT]) begin
            rd_word[icsr_pkg::PRIO_EXT_BIT]  = prio_ext_d;  // RL1
            rd_word[icsr_pkg::PRIO_RSVD_BIT] = 1'b1;        // RL3
        end else if (asel[icsr_pkg::REG_NEST_TRAP]) begin
            rd_word = trap_d;                               // RL15
            rd_word[icsr_pkg::NEST_DIS_BIT] = nest_dis_d;
        end else if (asel[icsr_pkg::REG_VEC_EDGE]) begin
            rd_word[NUM_EXT-1:0] = pol_d;
            rd_word[icsr_pkg::ALT_TABLE_BIT] = alt_d;
            rd_word[icsr_pkg::TEMP_DIS_BIT]  = temp_dis_d;  // RL8
        end else if (asel[icsr_pkg::REG_FLAGS0]) begin
            rd_word = flags0_d;
        end else if (asel[icsr_pkg::REG_FLAGS1]) begin
            rd_word = flags1_d;
        end else if (asel[icsr_pkg::REG_CPU_FIELD]) begin
            rd_word[icsr_pkg::FIELD_MSB:icsr_pkg::FIELD_LSB] = field_d;
        end
        hrdata_d = hrdata_q;
        if (addr_phase && !hwrite) begin
            hrdata_d = {16'h0000, rd_word};
        end
        // Byte and halfword writes are dropped; only whole words land
        wsel_d = '0;
        if (addr_phase && hwrite && (hsize == icsr_pkg::HSIZE_WORD)) begin
            wsel_d = asel;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prio_ext_q <= icsr_pkg::RST_BIT;
            nest_dis_q <= icsr_pkg::RST_BIT;
            trap_q     <= icsr_pkg::RST_WORD;
            alt_q      <= icsr_pkg::RST_BIT;
            pol_q      <= '0;
            flags0_q   <= icsr_pkg::RST_WORD;
            flags1_q   <= icsr_pkg::RST_WORD;
            field_q    <= icsr_pkg::RST_FIELD;
            wsel_q     <= '0;
            hrdata_q   <= 32'h0000_0000;
        end else begin
            prio_ext_q <= prio_ext_d;
            nest_dis_q <= nest_dis_d;
            trap_q     <= trap_d;
            alt_q      <= alt_d;
            pol_q      <= pol_d;
            flags0_q   <= flags0_d;
            flags1_q   <= flags1_d;
            field_q    <= field_d;
            wsel_q     <= wsel_d;
            hrdata_q   <= hrdata_d;
        end
    end

    // No wait states, so back-to-back transfers are fine
    assign hreadyout              = 1'b1;
    assign hresp                  = icsr_pkg::HRESP_OKAY;
    assign hrdata                 = hrdata_q;
    assign cpu_priority_level     = {prio_ext_q, field_q};                  // RL2
    assign user_irq_disabled      = (field_q == icsr_pkg::FIELD_ALL_OFF);   // RL18
    assign nesting_disable        = nest_dis_q;
    assign alternate_table_select = alt_q;
    assign ext_irq_polarity       = pol_q;
    assign request_flags_bank0    = flags0_q;
    assign request_flags_bank1    = flags1_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_rl1;
        prio_ext_set |=> cpu_priority_level[3] ##1
            (cpu_priority_level[3] || $past(wsel_q[icsr_pkg::REG_PRIO_EXT]) ||
             $past(prio_ext_set));
    endproperty
    a_rl1: assert property (p_rl1) else $error("extension bit not set by hardware"); // RL1

    property p_rl2;
        cpu_field_load |=> cpu_priority_level[2:0] == $past(cpu_field_value);
    endproperty
    a_rl2: assert property (p_rl2) else $error("priority level field mismatch"); // RL2

    property p_rl3;
        addr_phase && !hwrite && haddr[7:0] == icsr_pkg::OFS_PRIO_EXT
            |=> hrdata[2] && hrdata[1:0] == 2'h0 && hrdata[31:4] == 28'h000_0000;
    endproperty
    a_rl3: assert property (p_rl3) else $error("extension register fixed bits wrong"); // RL3

    property p_rl4;
        wsel_q[icsr_pkg::REG_NEST_TRAP] |=> nesting_disable == $past(hwdata[15]);
    endproperty
    a_rl4: assert property (p_rl4) else $error("nesting disable not written"); // RL4

    property p_rl5;
        trap_arith_set && trap_address_set |=> trap_q[4] && trap_q[3];
    endproperty
    a_rl5: assert property (p_rl5) else $error("trap flag not set"); // RL5

    property p_rl6;
        trap_osc_set |=> trap_q[icsr_pkg::OSC_BIT];
    endproperty
    a_rl6: assert property (p_rl6) else $error("oscillator trap flag not set"); // RL6

    property p_rl7;
        wsel_q[icsr_pkg::REG_VEC_EDGE] |=> alternate_table_select == $past(hwdata[15]);
    endproperty
    a_rl7: assert property (p_rl7) else $error("vector table select not written"); // RL7

    property p_rl8;
        addr_phase && !hwrite && haddr[7:0] == icsr_pkg::OFS_VEC_EDGE
            |=> hrdata[14] == $past(temp_disable_active);
    endproperty
    a_rl8: assert property (p_rl8) else $error("temporary disable status wrong"); // RL8

    property p_rl12;
        request_flags_bank0[icsr_pkg::FLAGS0_GAP_BIT] == 1'b0 &&
            request_flags_bank1[icsr_pkg::FLAGS1_GAP_BIT] == 1'b0;
    endproperty
    a_rl12: assert property (p_rl12) else $error("unimplemented flag bit set"); // RL12

    property p_rl15;
        addr_phase && !hwrite && haddr[7:0] == icsr_pkg::OFS_NEST_TRAP
            |=> hrdata[14:5] == 10'h000 && hrdata[0] == 1'b0;
    endproperty
    a_rl15: assert property (p_rl15) else $error("unimplemented control bits read nonzero"); // RL15

    property p_rl16;
        request_flags_bank0[7] && !wsel_q[icsr_pkg::REG_FLAGS0] |=> request_flags_bank0[7];
    endproperty
    a_rl16: assert property (p_rl16) else $error("flag cleared without software"); // RL16

    property p_rl17;
        nesting_disable && wsel_q[icsr_pkg::REG_CPU_FIELD] && !cpu_field_load
            |=> $stable(cpu_priority_level[2:0]);
    endproperty
    a_rl17: assert property (p_rl17) else $error("field written while nesting disabled"); // RL17

    property p_rl18;
        cpu_field_load && cpu_field_value == 3'h7 |=> user_irq_disabled;
    endproperty
    a_rl18: assert property (p_rl18) else $error("user interrupts not masked"); // RL18

    property p_rl19;
        ext_irq_edge[1] |=> request_flags_bank1[4] && !ext_irq_edge[1];
    endproperty
    a_rl19: assert property (p_rl19) else $error("external edge handling wrong"); // RL19

    property p_rl11;
        ext_irq_edge[0] |=> request_flags_bank0[icsr_pkg::EXT0_FLAG_BIT];
    endproperty
    a_rl11: assert property (p_rl11) else $error("external line zero flag not set"); // RL11

    property p_rl13;
        ext_irq_edge[2] |=> request_flags_bank1[icsr_pkg::EXT2_FLAG_BIT];
    endproperty
    a_rl13: assert property (p_rl13) else $error("external line two flag not set"); // RL13

    property p_rl20;
        wsel_q[icsr_pkg::REG_FLAGS0] && periph_set_bank0[3] |=> request_flags_bank0[3];
    endproperty
    a_rl20: assert property (p_rl20) else $error("hardware set lost to write"); // RL20

    c_trap:    cover property (trap_stack_set ##1 trap_q[2]);
    c_collide: cover property (wsel_q[icsr_pkg::REG_FLAGS1] && periph_set_bank1[8]);
    c_ext:     cover property (ext_irq_edge[0] ##1 request_flags_bank0[0]);
    c_rd:      cover property (addr_phase && !hwrite && haddr[7:0] == icsr_pkg::OFS_VEC_EDGE);

endmodule

// file: verif/icsr_partner.sv
`timescale 1ns/1ps
module icsr_partner (
    // Clock
    input  wire logic   hclk,
    // Pins and event lines toward the block
    output logic [4:0]  ext_irq_pin,
    output logic [15:0] periph_set_bank0,
    output logic [15:0] periph_set_bank1,
    output logic [3:0]  trap_set,
    output logic        prio_ext_set,
    output logic        cpu_field_load,
    output logic [2:0]  cpu_field_value,
    output logic        temp_disable_active
);
    initial begin
        ext_irq_pin         = 5'h00;
        periph_set_bank0    = 16'h0000;
        periph_set_bank1    = 16'h0000;
        trap_set            = 4'h0;
        prio_ext_set        = 1'b0;
        cpu_field_load      = 1'b0;
        cpu_field_value     = 3'h0;
        temp_disable_active = 1'b0;
    end

    // One-cycle set pulses; peripherals never clear flags themselves
    task automatic fire(input logic [15:0] b0, input logic [15:0] b1,
                        input logic [3:0] tr, input logic px);
        @(posedge hclk);
        periph_set_bank0 <= b0;
        periph_set_bank1 <= b1;
        trap_set         <= tr;
        prio_ext_set     <= px;
        @(posedge hclk);
        periph_set_bank0 <= 16'h0000;
        periph_set_bank1 <= 16'h0000;
        trap_set         <= 4'h0;
        prio_ext_set     <= 1'b0;
    endtask

    task automatic load_field(input logic [2:0] v);
        @(posedge hclk);
        cpu_field_load  <= 1'b1;
        cpu_field_value <= v;
        @(posedge hclk);
        cpu_field_load  <= 1'b0;
    endtask

    task automatic drive_pin(input int k, input logic lvl);
        @(posedge hclk);
        ext_irq_pin[k] <= lvl;
    endtask

    task automatic set_disable(input logic lvl);
        @(posedge hclk);
        temp_disable_active <= lvl;
    endtask
endmodule

// file: verif/icsr_regs_tb.sv
`timescale 1ns/1ps
module icsr_regs_tb;
    logic        hclk, hresetn, hsel, hwrite, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata, v, ev;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [4:0]  pin, pol, edg;
    logic [15:0] sb0, sb1, f0, f1, b;
    logic [3:0]  trap, level;
    logic        pxs, fld, tdis, uid, nest, alt;
    logic [2:0]  fval;
    logic [7:0]  a;
    int          fail_count, n_tests;
    int          edge_cnt [5];

    icsr_partner pm (.hclk(hclk), .ext_irq_pin(pin), .periph_set_bank0(sb0),
        .periph_set_bank1(sb1), .trap_set(trap), .prio_ext_set(pxs), .cpu_field_load(fld),
        .cpu_field_value(fval), .temp_disable_active(tdis));

    icsr_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .ext_irq_pin(pin),
        .periph_set_bank0(sb0), .periph_set_bank1(sb1), .trap_arith_set(trap[3]),
        .trap_address_set(trap[2]), .trap_stack_set(trap[1]), .trap_osc_set(trap[0]),
        .prio_ext_set(pxs), .cpu_field_load(fld), .cpu_field_value(fval),
        .temp_disable_active(tdis), .cpu_priority_level(level), .user_irq_disabled(uid),
        .nesting_disable(nest), .alternate_table_select(alt), .ext_irq_polarity(pol),
        .ext_irq_edge(edg), .request_flags_bank0(f0), .request_flags_bank1(f1));

    always #4 hclk = ~hclk;

    always @(posedge hclk) begin
        for (int i = 0; i < 5; i++) begin
            if (edg[i] === 1'b1) edge_cnt[i] <= edge_cnt[i] + 1;
        end
    end

    // Writable bits of each register
    function automatic logic [31:0] wmask(input logic [7:0] ad);
        case (ad)
            8'h04:   return 32'h0000_801E;
            8'h08:   return 32'h0000_801F;
            8'h0C:   return 32'h0000_7FFF;
            8'h10:   return 32'h0000_FFDF;
            8'h14:   return 32'h0000_00E0;
            default: return 32'h0000_0000;
        endcase
    endfunction

    function automatic logic [31:0] rst_val(input logic [7:0] ad);
        return (ad == 8'h00) ? 32'h0000_0004 : 32'h0000_0000;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic [7:0] ad, input logic wr, input logic [31:0] d,
                        input logic [2:0] sz);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, ad};
        hwrite <= wr;
        htrans <= 2'b10;
        hsize  <= sz;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        v = hrdata;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        xfer(ad, 1'b1, d, icsr_pkg::HSIZE_WORD);
    endtask

    task automatic chk_rd(input logic [7:0] ad, input logic [31:0] e);
        xfer(ad, 1'b0, 32'h0000_0000, icsr_pkg::HSIZE_WORD);
        check(v, e);
        check(hresp, icsr_pkg::HRESP_OKAY);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        end_of_test;
    end

    initial begin
        hclk = 0; hresetn = 0; hsel = 0; haddr = 0; hwrite = 0;
        htrans = 0; hsize = icsr_pkg::HSIZE_WORD; hwdata = 0;
        fail_count = 0; n_tests = 0;
        for (int i = 0; i < 5; i++) edge_cnt[i] = 0;
        void'($urandom(43));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 7; i++) chk_rd(8'(i * 4), rst_val(8'(i * 4)));
        $display("reset values done");
        for (int i = 0; i < 7; i++) begin
            wr(8'(i * 4), 32'hFFFF_FFFF);
            // Field write refused: nesting was disabled four steps earlier
            ev = (i == 5) ? 32'h0000_0000 : (wmask(8'(i * 4)) | rst_val(8'(i * 4)));
            chk_rd(8'(i * 4), ev);
        end
        // Unlock, load the field, lock again
        wr(8'h04, 32'h0000_0000);
        wr(8'h14, 32'hFFFF_FFFF);
        wr(8'h04, 32'hFFFF_FFFF);
        @(negedge hclk);
        check(nest, 1'b1);
        check(alt, 1'b1);
        check(pol, 5'h1F);
        check(level, 4'h7);
        check(uid, 1'b1);
        wr(8'h14, 32'h0000_0000);
        chk_rd(8'h14, 32'h0000_00E0);
        xfer(8'h0C, 1'b1, 32'h0000_0000, 3'h0);
        chk_rd(8'h0C, 32'h0000_7FFF);
        for (int i = 1; i < 6; i++) wr(8'(i * 4), 32'h0000_0000);
        chk_rd(8'h14, 32'h0000_0000);
        $display("access kinds done");
        repeat (20) begin
            a = 8'(4 + 4 * ($urandom % 4));
            b = 16'($urandom);
            wr(a, {16'h0000, b});
            chk_rd(a, {16'h0000, b} & wmask(a));
        end
        for (int i = 1; i < 5; i++) wr(8'(i * 4), 32'h0000_0000);
        $display("random access done");
        wr(8'h04, 32'h0000_8000);
        for (int k = 0; k < 8; k++) begin
            pm.load_field(3'(k));
            @(negedge hclk);
            check(level, {1'b0, 3'(k)});
            check(uid, k == 7);
        end
        pm.fire(16'h0000, 16'h0000, 4'h0, 1'b1);
        @(negedge hclk);
        check(level, 4'hF);
        chk_rd(8'h00, 32'h0000_000C);
        wr(8'h00, 32'h0000_0000);
        chk_rd(8'h00, 32'h0000_0004);
        $display("priority level done");
        // Last pass raises two traps at once; nesting stays disabled throughout
        for (int i = 0; i < 5; i++) begin
            pm.fire(16'h0000, 16'h0000, (i == 4) ? 4'hC : 4'(1 << i), 1'b0);
            ev = (i == 4) ? 32'h0000_8018 : (32'h0000_8000 | (32'h2 << i));
            chk_rd(8'h04, ev);
            wr(8'h04, 32'h0000_8000);
        end
        chk_rd(8'h04, 32'h0000_8000);
        for (int j = 0; j < 2; j++) begin
            // Bit three always collides with the clearing write
            b = (16'h0001 << ($urandom % 15)) | 16'h0008;
            if (j == 1) b[5] = 1'b0;
            fork
                wr(8'(8'h0C + 4 * j), 32'h0000_0000);
                begin
                    @(posedge hclk);
                    pm.fire(j == 0 ? b : 16'h0000, j == 1 ? b : 16'h0000, 4'h0, 1'b0);
                end
            join
            chk_rd(8'(8'h0C + 4 * j), {16'h0000, b});
            wr(8'(8'h0C + 4 * j), 32'h0000_0000);
        end
        $display("traps and events done");
        pm.set_disable(1'b1);
        chk_rd(8'h08, 32'h0000_4000);
        wr(8'h08, 32'h0000_0000);
        chk_rd(8'h08, 32'h0000_4000);
        pm.set_disable(1'b0);
        chk_rd(8'h08, 32'h0000_0000);
        $display("temporary disable done");
        wr(8'h08, 32'h0000_0002);
        for (int k = 0; k < 5; k++) begin
            pm.drive_pin(k, 1'b1);
            repeat (12) @(posedge hclk);
            pm.drive_pin(k, 1'b0);
            repeat (12) @(posedge hclk);
        end
        for (int k = 0; k < 5; k++) check(edge_cnt[k], 1);
        chk_rd(8'h0C, 32'h0000_0001);
        chk_rd(8'h10, 32'h0000_2010);
        check(f0, 16'h0001);
        check(f1, 16'h2010);
        $display("external pins done");
        end_of_test;
    end
endmodule
